//--- hdl/ssr_receiver.sv
// synchronous slave receive path with ahb-lite register slave and interrupt logic
//
// Decided for this implementation: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
// Notes on behaviour
// - slave reception works as master reception apart from sleep and single receive.
// - single receive enable is stored but never steers reception.
// - continuous receive must be set before sleep for reception to continue.
// - in sleep or idle with continuous receive on, words keep arriving.
// - a finished word moves from the shift register into the data buffer unless the buffer still holds an unread word.
// - word done in low power with interrupt enable raises a wake request unless the word overruns.
// - nine bit select makes words nine bits long instead of eight.
// - nothing is received while continuous receive enable is clear.
// - receive flag is set when a word completes.
// - interrupt request only when receive flag and its enable are both set.
// - ninth bit, framing and overrun errors read from receive status.
// - low eight received bits read from the receive data register.
// - clearing continuous receive clears latched errors.
module ssr_receiver (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic sck_i,
	input wire logic sdata_i,
	input wire logic low_power_i,
	output logic sck_o,
	output logic sck_oe_o,
	output logic wake_o,
	output logic rcv_irq_o,
	output logic irq_o
);
	typedef struct packed {
		logic [1:0] sck_sync;
		logic [1:0] dat_sync;
		logic sck_prev;
		logic [8:0] shift;
		logic [3:0] count;
		logic [7:0] rx_data;
		logic rx_flag;
		logic [7:0] rstat;
		logic [7:0] xstat;
		logic [7:0] intctl;
		logic [2:0] irq_stat;
		logic [2:0] irq_mask;
		logic wake;
		logic dp_act;
		logic dp_write;
		logic [7:0] dp_addr;
		logic [31:0] rdata;
	} ssr_state_t;

	ssr_state_t s_q, s_d;

	function automatic logic [31:0] ssr_byte(input logic [7:0] b);
		ssr_byte = {24'h000000, b};
	endfunction

	// nonseq and seq both open a transfer; idle and busy open nothing
	function automatic logic ssr_addr_phase(input logic sel, input logic rdy, input logic [1:0] trans);
		ssr_addr_phase = sel & rdy & trans[1];
	endfunction

	// read mux, built from the registered state so the data phase sees a settled word
	function automatic logic [31:0] ssr_read_word(input ssr_state_t st, input logic [7:0] addr);
		logic [31:0] w;
		w = 32'h00000000;
		case (addr)
			ssr_pkg::ADDR_RCV_STATUS: begin
				w = ssr_byte(st.rstat);
			end
			ssr_pkg::ADDR_RCV_DATA: begin
				w = ssr_byte(st.rx_data);
			end
			ssr_pkg::ADDR_XMT_STATUS: begin
				w = ssr_byte(st.xstat);
			end
			ssr_pkg::ADDR_INT_CTRL: begin
				w = ssr_byte(st.intctl);
			end
			ssr_pkg::ADDR_IRQ_STATUS: begin
				w = ssr_byte({5'h00, st.irq_stat});
			end
			ssr_pkg::ADDR_IRQ_MASK: begin
				w = ssr_byte({5'h00, st.irq_mask});
			end
			ssr_pkg::ADDR_POWER: begin
				w = ssr_byte({6'h00, st.rx_flag, st.wake});
			end
			default: begin
				// unmapped offsets read as zero
				w = 32'h00000000;
			end
		endcase
		ssr_read_word = w;
	endfunction

	// the newest bit enters at the top, so an eight bit word ends one place higher
	function automatic logic [7:0] ssr_capture_data(input logic [8:0] sh, input logic nine);
		if (nine) begin
			ssr_capture_data = sh[7:0];
		end else begin
			ssr_capture_data = sh[8:1];
		end
	endfunction

	// the ninth bit reads zero in eight bit mode rather than a stale shift bit
	function automatic logic ssr_capture_ninth(input logic [8:0] sh, input logic nine);
		if (nine) begin
			ssr_capture_ninth = sh[8];
		end else begin
			ssr_capture_ninth = 1'b0;
		end
	endfunction

	logic receiving;
	logic sck_rise;
	logic [3:0] word_len;
	logic word_done;
	logic rd_data_hit;
	logic [2:0] irq_set;

	always_comb begin
		// sync mode, port enable, external clock and continuous receive selected; single receive is ignored
		receiving = s_q.rstat[ssr_pkg::RS_SERIAL_PORT_ENABLE] & s_q.xstat[ssr_pkg::TS_SYNC_MODE] &
			~s_q.xstat[ssr_pkg::TS_CLOCK_SOURCE] & s_q.rstat[ssr_pkg::RS_CONT_RECEIVE];
		sck_rise = s_q.sck_sync[1] & ~s_q.sck_prev;
		word_len = s_q.rstat[ssr_pkg::RS_NINE_BIT_SELECT] ? 4'h9 : 4'h8;
		// low_power_i does not gate reception, only the wake request: reception carries on in sleep or idle
		word_done = receiving & sck_rise & (s_q.count == word_len - 4'h1);
		rd_data_hit = s_q.dp_act & ~s_q.dp_write & (s_q.dp_addr == ssr_pkg::ADDR_RCV_DATA);
	end

	always_comb begin
		logic [8:0] nshift;
		logic [31:0] rd;
		logic landed;
		nshift = 9'h000;
		rd = 32'h00000000;
		landed = 1'b0;
		irq_set = 3'h0;
		s_d = s_q;
		s_d.sck_sync = {s_q.sck_sync[0], sck_i};
		s_d.dat_sync = {s_q.dat_sync[0], sdata_i};
		s_d.sck_prev = s_q.sck_sync[1];

		// data-phase write lands on the register addressed in the previous cycle
		if (s_q.dp_act && s_q.dp_write) begin
			case (s_q.dp_addr)
				ssr_pkg::ADDR_RCV_STATUS: begin
					s_d.rstat[7:3] = hwdata_i[7:3];
					if (!hwdata_i[ssr_pkg::RS_CONT_RECEIVE]) begin
						s_d.rstat[ssr_pkg::RS_FRAMING_ERR] = 1'b0;
						s_d.rstat[ssr_pkg::RS_OVERRUN_ERR] = 1'b0;
					end
				end
				ssr_pkg::ADDR_XMT_STATUS: s_d.xstat = {hwdata_i[7:2], s_q.xstat[1:0]};
				ssr_pkg::ADDR_INT_CTRL: s_d.intctl = hwdata_i[7:0];
				ssr_pkg::ADDR_IRQ_MASK: s_d.irq_mask = hwdata_i[2:0];
				ssr_pkg::ADDR_POWER: s_d.wake = s_q.wake & ~hwdata_i[0];
				default: ;
			endcase
		end

		// shifting, lsb first as in a standard synchronous port
		if (!receiving) begin
			s_d.count = 4'h0;
		end else if (sck_rise) begin
			nshift = {s_q.dat_sync[1], s_q.shift[8:1]};
			s_d.shift = nshift;
			s_d.count = s_q.count + 4'h1;
			if (word_done) begin
				s_d.count = 4'h0;
				// an unread word blocks the new one; data kept, overrun latched
				if (s_q.rx_flag && !rd_data_hit) begin
					s_d.rstat[ssr_pkg::RS_OVERRUN_ERR] = 1'b1;
					irq_set[ssr_pkg::IRQ_OVERRUN] = 1'b1;
				end else begin
					s_d.rx_data = ssr_capture_data(nshift, word_len == 4'h9);
					s_d.rstat[ssr_pkg::RS_NINTH_BIT] = ssr_capture_ninth(nshift, word_len == 4'h9);
					s_d.rx_flag = 1'b1;
					landed = 1'b1;
					irq_set[ssr_pkg::IRQ_WORD_DONE] = 1'b1;
					if (low_power_i && s_q.intctl[ssr_pkg::IC_RCV_IRQ_EN]) begin
						s_d.wake = 1'b1;
						irq_set[ssr_pkg::IRQ_WAKE] = 1'b1;
					end
				end
			end
		end
		// framing error has no meaning in synchronous mode and stays clear
		s_d.rstat[ssr_pkg::RS_FRAMING_ERR] = 1'b0;

		// reading the data buffer empties it unless a new word lands now
		// a word that lands in the same cycle as the read keeps the flag up
		if (rd_data_hit && !landed) begin
			s_d.rx_flag = 1'b0;
		end
		if (!s_q.rstat[ssr_pkg::RS_CONT_RECEIVE] && !s_q.rstat[ssr_pkg::RS_SERIAL_PORT_ENABLE]) begin
			s_d.rx_flag = 1'b0;
		end

		// sticky status: read clears, a set in the same cycle wins
		if (s_q.dp_act && !s_q.dp_write && s_q.dp_addr == ssr_pkg::ADDR_IRQ_STATUS) begin
			s_d.irq_stat = irq_set;
		end else begin
			s_d.irq_stat = s_q.irq_stat | irq_set;
		end

		// address phase
		s_d.dp_act = ssr_addr_phase(hsel_i, hready_i, htrans_i);
		s_d.dp_write = hwrite_i;
		s_d.dp_addr = haddr_i[7:0];
		if (ssr_addr_phase(hsel_i, hready_i, htrans_i) && !hwrite_i) begin
			rd = ssr_read_word(s_q, haddr_i[7:0]);
			s_d.rdata = rd;
		end

		if (rst_i) begin
			s_d = '0;
			s_d.rstat = ssr_pkg::RCV_STATUS_RESET;
			s_d.xstat = ssr_pkg::XMT_STATUS_RESET;
			s_d.intctl = ssr_pkg::INT_CTRL_RESET;
			s_d.irq_mask = ssr_pkg::IRQ_MASK_RESET;
		end
	end

	always_ff @(posedge clk_i) begin
		s_q <= s_d;
	end

	assign hrdata_o = s_q.rdata;
	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;
	// slave only: the shift clock is an input, the driver stays off
	assign sck_o = 1'b0;
	assign sck_oe_o = 1'b0;
	assign wake_o = s_q.wake;
	assign rcv_irq_o = s_q.rx_flag & s_q.intctl[ssr_pkg::IC_RCV_IRQ_EN];
	assign irq_o = |(s_q.irq_stat & s_q.irq_mask);
endmodule // ssr_receiver

//--- hdl/ssr_pkg.sv
// package: register map, field positions and reset values of the synchronous slave receiver
package ssr_pkg;
	// byte addresses, one aligned word each
	localparam logic [7:0] ADDR_RCV_STATUS = 8'h00;
	localparam logic [7:0] ADDR_RCV_DATA = 8'h04;
	localparam logic [7:0] ADDR_XMT_STATUS = 8'h08;
	localparam logic [7:0] ADDR_INT_CTRL = 8'h0c;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
	localparam logic [7:0] ADDR_POWER = 8'h18;
	// receive_status_control bits
	localparam int RS_SERIAL_PORT_ENABLE = 7;
	localparam int RS_NINE_BIT_SELECT = 6;
	localparam int RS_SINGLE_RECEIVE = 5;
	localparam int RS_CONT_RECEIVE = 4;
	localparam int RS_ADDRESS_DETECT = 3;
	localparam int RS_FRAMING_ERR = 2;
	localparam int RS_OVERRUN_ERR = 1;
	localparam int RS_NINTH_BIT = 0;
	// transmit_status_control bits used here
	localparam int TS_CLOCK_SOURCE = 7;
	localparam int TS_SYNC_MODE = 4;
	// interrupt_control bits
	localparam int IC_GLOBAL_EN = 7;
	localparam int IC_PERIPH_EN = 6;
	// receive interrupt enable lives beside the two global enables
	localparam int IC_RCV_IRQ_EN = 5;
	// sticky status / mask bits
	localparam int IRQ_WORD_DONE = 0;
	localparam int IRQ_OVERRUN = 1;
	localparam int IRQ_WAKE = 2;
	localparam logic [7:0] RCV_STATUS_RESET = 8'h00;
	localparam logic [7:0] XMT_STATUS_RESET = 8'h02;
	localparam logic [7:0] INT_CTRL_RESET = 8'h00;
	localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

//--- verif/ssr_receiver_asserts.sv
// checker: port-level properties of the receiver
`timescale 1ns/1ps
module ssr_receiver_asserts (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic hsel_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [31:0] hrdata_o,
	input wire logic hreadyout_o,
	input wire logic hresp_o,
	input wire logic sck_i,
	input wire logic low_power_i,
	input wire logic sck_oe_o,
	input wire logic wake_o,
	input wire logic rcv_irq_o,
	input wire logic irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire logic wr = hsel_i && htrans_i[1] && hwrite_i;
	wire logic rd = hsel_i && htrans_i[1] && !hwrite_i;
	a_zero_wait: assert property (hreadyout_o && !hresp_o) else $error("stall or error");
	a_clk_undriven: assert property (!sck_oe_o) else $error("clock driven");
	a_reset_quiet: assert property ($fell(rst_i) |-> !irq_o && !wake_o && hrdata_o == 32'h0) else $error("reset");
	a_read_stands: assert property (!rd |=> $stable(hrdata_o)) else $error("read data moved");
	a_wake_in_sleep: assert property ($rose(wake_o) |-> $past(low_power_i)) else $error("wake awake");
	a_wake_on_word: assert property ((!sck_i) [*8] |-> !$rose(wake_o)) else $error("wake no word");
	a_wake_clear: assert property ($fell(wake_o) |-> $past(wr, 2) || $past(wr, 3)) else $error("wake lost");
	a_irq_cause: assert property ((!sck_i) [*8] ##0 !$past(wr, 2) && !$past(wr, 3) |-> !$rose(irq_o))
		else $error("irq no cause");
	c_wake: cover property ($rose(wake_o));
	c_rcv: cover property ($rose(rcv_irq_o));
	c_irq_done: cover property ($fell(irq_o));
endmodule // ssr_receiver_asserts
bind ssr_receiver ssr_receiver_asserts ssr_receiver_asserts_inst (.*);

//--- verif/ssr_master_model.sv
// partner model: external master clocking words into the receiver
`timescale 1ns/1ps
module ssr_master_model (
	output logic sck_o,
	output logic sdata_o
);
	initial begin
		sck_o = 1'b0;
		sdata_o = 1'b0;
	end
	// clock stands low between frames; data moves only while it is low
	task automatic send(input logic [8:0] w, input int n);
		#37;
		for (int i = 0; i < n; i++) begin
			sdata_o = w[i];
			#100 sck_o = 1'b1;
			#100 sck_o = 1'b0;
		end
		sdata_o = ~sdata_o;
	endtask
endmodule // ssr_master_model

//--- verif/ssr_receiver_test.sv
// testbench: register-level tests of the synchronous slave receiver
`timescale 1ns/1ps
module ssr_receiver_test;
	logic clk_i = 0, rst_i = 1, hsel_i = 0, hwrite_i = 0, low_power_i = 0;
	logic [1:0] htrans_i = 2'h0;
	logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o;
	logic hreadyout_o, sck_i, sdata_i, wake_o, rcv_irq_o, irq_o;
	int n_errors = 0, total_checks = 0;
	always #12.5 clk_i = ~clk_i;
	ssr_receiver ssr_receiver_inst (.*, .hsize_i(3'h2), .hready_i(hreadyout_o), .hresp_o(), .sck_o(), .sck_oe_o());
	ssr_master_model ssr_master_model_inst (.sck_o(sck_i), .sdata_o(sdata_i));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// a read compares against d, a write sends d
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		haddr_i <= {24'h0, a};
		hwrite_i <= w;
		hsel_i <= 1'b1;
		htrans_i <= 2'h2;
		do @(posedge clk_i); while (hreadyout_o !== 1'b1);
		htrans_i <= 2'h0;
		hwdata_i <= d;
		do @(posedge clk_i); while (hreadyout_o !== 1'b1);
		if (!w) chk(hrdata_o, d);
	endtask
	task automatic word(input logic [8:0] w, input int n);
		ssr_master_model_inst.send(w, n);
		repeat (8) @(posedge clk_i);
	endtask
	task automatic end_sim;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#200000;
		n_errors++;
		end_sim;
	end
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		acc(0, ssr_pkg::ADDR_RCV_STATUS, {24'h0, ssr_pkg::RCV_STATUS_RESET});
		acc(0, ssr_pkg::ADDR_XMT_STATUS, {24'h0, ssr_pkg::XMT_STATUS_RESET});
		acc(0, 8'h1c, 32'h0);
		$display("test reset done");
		acc(1, ssr_pkg::ADDR_XMT_STATUS, 32'h10);
		acc(1, ssr_pkg::ADDR_INT_CTRL, 32'he0);
		acc(1, ssr_pkg::ADDR_IRQ_MASK, 32'h7);
		acc(1, ssr_pkg::ADDR_RCV_STATUS, 32'h80);
		word(9'h0a5, 8);
		acc(0, ssr_pkg::ADDR_POWER, 32'h0);
		acc(1, ssr_pkg::ADDR_RCV_STATUS, 32'hb0);
		word(9'h0a5, 8);
		chk({30'h0, rcv_irq_o, irq_o}, 32'h3);
		acc(0, ssr_pkg::ADDR_IRQ_STATUS, 32'h1);
		acc(0, ssr_pkg::ADDR_RCV_DATA, 32'ha5);
		acc(0, ssr_pkg::ADDR_POWER, 32'h0);
		chk({30'h0, rcv_irq_o, irq_o}, 32'h0);
		$display("test eight bit done");
		word(9'h011, 8);
		word(9'h022, 8);
		acc(0, ssr_pkg::ADDR_RCV_STATUS, 32'hb2);
		acc(0, ssr_pkg::ADDR_RCV_DATA, 32'h11);
		acc(1, ssr_pkg::ADDR_RCV_STATUS, 32'h80);
		acc(0, ssr_pkg::ADDR_RCV_STATUS, 32'h80);
		$display("test overrun done");
		acc(1, ssr_pkg::ADDR_RCV_STATUS, 32'hd0);
		low_power_i <= 1'b1;
		word(9'h1c3, 9);
		chk({31'h0, wake_o}, 32'h1);
		acc(0, ssr_pkg::ADDR_RCV_STATUS, 32'hd1);
		acc(0, ssr_pkg::ADDR_RCV_DATA, 32'hc3);
		acc(1, ssr_pkg::ADDR_POWER, 32'h1);
		low_power_i <= 1'b0;
		acc(0, ssr_pkg::ADDR_POWER, 32'h0);
		$display("test nine bit sleep done");
		end_sim;
	end
endmodule // ssr_receiver_test
